/* File: design/optcfg_pkg.sv */
/*
 Package for the option byte loader: flash offsets, field positions,
 reset values, decoded enumerations and software register offsets.
 Assumes a byte-wide flash read port with fixed latency.
*/
`default_nettype none
package optcfg_pkg;
  // Flash byte addresses of the option area
  localparam logic [12:0] OPT_BASE_PRIMARY = 13'h0080;
  localparam logic [12:0] OPT_BASE_ALTERNATE = 13'h1080;
  localparam int OPT_BYTE_COUNT = 5;
  localparam logic [2:0] IDX_WDT_OSC = 3'h0;
  localparam logic [2:0] IDX_POC = 3'h1;
  localparam logic [2:0] IDX_DEBUG = 3'h4;
  localparam logic [2:0] IDX_POC_PRIMARY = 3'h1;
  // Field positions of the watchdog/oscillator, mode and debug bytes
  localparam int POS_OSC_LOCK = 0;
  localparam int POS_PERIOD_LO = 1;
  localparam int POS_AUTOSTART = 4;
  localparam int POS_WINDOW_LO = 5;
  localparam int POS_POC_MODE = 0;
  localparam int POS_DEBUG_LO = 0;
  // Values held before and during the fetch
  localparam logic [7:0] RESET_OPT_BYTE = 8'h00;
  localparam logic [17:0] WDT_BASE_CYCLES = 18'h00400;
  // Flash read latency in system clocks
  localparam int FLASH_LATENCY = 2;
  // Clocks after reset release before the first fetch
  localparam int SYNC_SETTLE = 5;
  // Software register offsets
  localparam logic [7:0] REG_WDT_OSC = 8'h80;
  localparam logic [7:0] REG_POC = 8'h81;
  localparam logic [7:0] REG_RSVD0 = 8'h82;
  localparam logic [7:0] REG_RSVD1 = 8'h83;
  localparam logic [7:0] REG_DEBUG = 8'h84;
  localparam logic [7:0] REG_OSC_CTRL = 8'h90;
  localparam logic [7:0] REG_STATUS = 8'h91;
  localparam int POS_HALT_REQ = 0;

  typedef enum logic [1:0] {
    WIN_25 = 2'b00,
    WIN_50 = 2'b01,
    WIN_75 = 2'b10,
    WIN_100 = 2'b11
  } window_t;

  typedef enum logic [1:0] {
    DBG_OFF = 2'b00,
    DBG_BAD = 2'b01,
    DBG_KEEP = 2'b10,
    DBG_ERASE = 2'b11
  } debug_mode_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } load_state_t;
endpackage : optcfg_pkg
`default_nettype wire

/* File: design/optcfg_store.sv */
/*
 Five-entry latch store for the fetched option bytes, registered read.
 Assumes one write port driven by the loader and one read index.
*/
`default_nettype none
module optcfg_store
  import optcfg_pkg::*;
#(
  parameter int DEPTH = OPT_BYTE_COUNT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= RESET_OPT_BYTE;
      end else if (wr_en && wr_idx == 3'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= RESET_OPT_BYTE;
    end else if (int'(rd_idx) < DEPTH) begin
      rd_data <= mem_q[rd_idx];
    end else begin
      rd_data <= RESET_OPT_BYTE;
    end
  end
endmodule : optcfg_store
`default_nettype wire

/* File: design/option_byte_config_decoder.sv */
/*
 Option byte loader and decoder. After reset release it reads the five
 option bytes from flash, from the alternate set when boot swap is set,
 latches them and drives decoded settings to the watchdog, slow
 oscillator, power-on-clear and debug units.
 Assumes the flash answers a read FLASH_LATENCY clocks after the request
 and that the boot swap and programmer-write pins are stable in reset.
*/
// Functional notes
// R1 - Window code picks 25, 50, 75 or 100 percent
// R2 - Autostart bit starts watchdog and access check
// R3 - Period code sets overflow 2^(10+code) slow cycles
// R4 - Programmer never stores period 000 window 00
// R5 - Unlocked oscillator halts on stop write only
// R6 - Unlocked: no watchdog clock in halt/stop
// R7 - Timer clock keeps running in halt/stop
// R8 - Watchdog counts during flash self-programming
// R9 - Programmer stores zero in watchdog byte bit 7
// R10 - Mode bit picks single or dual threshold
// R11 - Only external programmer may set mode bit
// R12 - Boot swap copies alternate mode byte to primary
// R13 - Mode changes only after full chip erase
// R14 - Programmer stores zero in mode bits 7..1
// R15 - Reserved bytes and copies programmed to zero
// R16 - Debug field: off, prohibited, keep, erase
// R17 - Programmer stores 00, 02 or 03 debug byte
// R18 - Boot swap fetches from alternate address set
// R19 - Fetch and apply bytes before CPU starts
// R20 - Decoded settings held constant until next reset
`default_nettype none
module option_byte_config_decoder
  import optcfg_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Flash read port
  output logic FLASH_RD,
  output logic [12:0] FLASH_ADDR,
  input wire logic [7:0] FLASH_DATA,
  // Flash mode bit write port toward the primary mode byte
  output logic POC_COPY_WR,
  output logic [7:0] POC_COPY_DATA,
  // Boot and programming state pins
  input wire logic BOOT_SWAP,
  input wire logic EXT_PROGRAMMER,
  input wire logic CHIP_ERASED,
  // Power mode and clock inputs
  input wire logic HALT_MODE,
  input wire logic STOP_MODE,
  input wire logic SLOW_OSC_TICK,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Decoded settings
  output logic CPU_START,
  output logic [1:0] WDT_WINDOW,
  output logic WDT_RUN,
  output logic ILLEGAL_ACCESS_EN,
  output logic [17:0] WDT_OVERFLOW_CYCLES,
  output logic SLOW_OSC_RUN,
  output logic WDT_TICK,
  output logic TIMER_TICK,
  output logic POC_DUAL,
  output logic DEBUG_EN,
  output logic DEBUG_ERASE_ON_FAIL
);
  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n_i;
  logic [2:0] swap_s_q, prog_s_q, erase_s_q, halt_s_q, stop_s_q, tick_s_q;
  logic swap_q, prog_q, erased_q, halt_q, stop_q, tick_q, tick_prev_q;
  logic tick_rise;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync_q[1];

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      swap_s_q <= 3'h0;
      prog_s_q <= 3'h0;
      erase_s_q <= 3'h0;
      halt_s_q <= 3'h0;
      stop_s_q <= 3'h0;
      tick_s_q <= 3'h0;
    end else begin
      swap_s_q <= {swap_s_q[1:0], BOOT_SWAP};
      prog_s_q <= {prog_s_q[1:0], EXT_PROGRAMMER};
      erase_s_q <= {erase_s_q[1:0], CHIP_ERASED};
      halt_s_q <= {halt_s_q[1:0], HALT_MODE};
      stop_s_q <= {stop_s_q[1:0], STOP_MODE};
      tick_s_q <= {tick_s_q[1:0], SLOW_OSC_TICK};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      swap_q <= 1'b0;
      prog_q <= 1'b0;
      erased_q <= 1'b0;
      halt_q <= 1'b0;
      stop_q <= 1'b0;
      tick_q <= 1'b0;
      tick_prev_q <= 1'b0;
    end else begin
      if (swap_s_q[2] == swap_s_q[1]) swap_q <= swap_s_q[2];
      if (prog_s_q[2] == prog_s_q[1]) prog_q <= prog_s_q[2];
      if (erase_s_q[2] == erase_s_q[1]) erased_q <= erase_s_q[2];
      if (halt_s_q[2] == halt_s_q[1]) halt_q <= halt_s_q[2];
      if (stop_s_q[2] == stop_s_q[1]) stop_q <= stop_s_q[2];
      if (tick_s_q[2] == tick_s_q[1]) tick_q <= tick_s_q[2];
      tick_prev_q <= tick_q;
    end
  end
  assign tick_rise = tick_q && !tick_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Fetch sequencer
  load_state_t state_q;
  logic [2:0] idx_q;
  logic [1:0] lat_q;
  logic swap_used_q;
  logic st_wr;
  logic [2:0] settle_q;

  // Pins need their synchronisers filled before the first read, or
  // byte 0 would come from the primary set on a swapped boot
  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= 3'h0;
    end else if (settle_q != 3'(SYNC_SETTLE)) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_FETCH;
      idx_q <= 3'h0;
      lat_q <= 2'h0;
      swap_used_q <= 1'b0;
      FLASH_RD <= 1'b0;
      FLASH_ADDR <= OPT_BASE_PRIMARY;
    end else begin
      FLASH_RD <= 1'b0;
      unique case (state_q)
        ST_FETCH: begin
          if (settle_q == 3'(SYNC_SETTLE)) begin
            FLASH_RD <= 1'b1;
            // Alternate set when swapped
            FLASH_ADDR <= (swap_q ? OPT_BASE_ALTERNATE : OPT_BASE_PRIMARY)
                          + 13'(idx_q); // R18
            swap_used_q <= swap_q;
            lat_q <= 2'(FLASH_LATENCY);
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (lat_q == 2'h1) begin
            if (idx_q == 3'(OPT_BYTE_COUNT - 1)) begin
              state_q <= ST_DONE;
            end else begin
              idx_q <= idx_q + 3'h1;
              state_q <= ST_FETCH;
            end
          end
          lat_q <= lat_q - 2'h1;
        end
        ST_DONE: begin
          state_q <= ST_DONE; // R20
        end
        default: state_q <= ST_FETCH;
      endcase
    end
  end
  assign st_wr = (state_q == ST_WAIT) && (lat_q == 2'h1);

  // CPU held until every byte is latched
  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      CPU_START <= 1'b0;
    end else begin
      CPU_START <= (state_q == ST_DONE); // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Option byte latches
  logic [7:0] opt_wdt_q, opt_poc_q, opt_dbg_q, st_rdata;
  logic [7:0] poc_byte;
  logic [2:0] st_ridx;

  // Mode bit is honoured only when set by the external programmer
  // after a full erase; self-programmed images fall back to default
  assign poc_byte = (prog_q && erased_q) ? FLASH_DATA
                    : RESET_OPT_BYTE; // R11 R13

  optcfg_store #(
    .DEPTH(OPT_BYTE_COUNT)
  ) u_store (
    .clk(CLOCK),
    .rst_n(rst_n_i),
    .wr_en(st_wr),
    .wr_idx(idx_q),
    .wr_data(idx_q == IDX_POC ? poc_byte : FLASH_DATA),
    .rd_idx(st_ridx),
    .rd_data(st_rdata)
  );

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_wdt_q <= RESET_OPT_BYTE;
      opt_poc_q <= RESET_OPT_BYTE;
      opt_dbg_q <= RESET_OPT_BYTE;
    end else if (st_wr) begin // R20
      if (idx_q == IDX_WDT_OSC) opt_wdt_q <= FLASH_DATA;
      if (idx_q == IDX_POC) opt_poc_q <= poc_byte;
      if (idx_q == IDX_DEBUG) opt_dbg_q <= FLASH_DATA;
    end
  end

  // Swapped boot writes the alternate mode byte back to primary
  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      POC_COPY_WR <= 1'b0;
      POC_COPY_DATA <= RESET_OPT_BYTE;
    end else begin
      POC_COPY_WR <= st_wr && swap_used_q && idx_q == IDX_POC; // R12
      if (st_wr && idx_q == IDX_POC) POC_COPY_DATA <= poc_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded settings, applied once loading is done
  logic done;
  logic osc_lock;
  logic [2:0] period_code;
  assign done = (state_q == ST_DONE);
  assign osc_lock = opt_wdt_q[POS_OSC_LOCK];
  assign period_code = opt_wdt_q[POS_PERIOD_LO +: 3];

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      WDT_WINDOW <= WIN_25;
      WDT_RUN <= 1'b0;
      ILLEGAL_ACCESS_EN <= 1'b0;
      WDT_OVERFLOW_CYCLES <= WDT_BASE_CYCLES;
      POC_DUAL <= 1'b0;
      DEBUG_EN <= 1'b0;
      DEBUG_ERASE_ON_FAIL <= 1'b0;
    end else if (done) begin
      WDT_WINDOW <= opt_wdt_q[POS_WINDOW_LO +: 2]; // R1
      // Counting continues through self-programming: no gating input
      WDT_RUN <= opt_wdt_q[POS_AUTOSTART]; // R2 R8
      ILLEGAL_ACCESS_EN <= opt_wdt_q[POS_AUTOSTART]; // R2
      WDT_OVERFLOW_CYCLES <= WDT_BASE_CYCLES << period_code; // R3
      POC_DUAL <= opt_poc_q[POS_POC_MODE]; // R10
      // Prohibited code 01 treated as disabled
      DEBUG_EN <= opt_dbg_q[POS_DEBUG_LO + 1]; // R16
      DEBUG_ERASE_ON_FAIL <= opt_dbg_q[POS_DEBUG_LO +: 2] == DBG_ERASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slow oscillator control and count clocks
  logic halt_req_q;

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_req_q <= 1'b0;
    end else if (REG_WR && REG_ADDR == REG_OSC_CTRL) begin
      halt_req_q <= REG_WDATA[POS_HALT_REQ];
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      SLOW_OSC_RUN <= 1'b1;
      WDT_TICK <= 1'b0;
      TIMER_TICK <= 1'b0;
    end else begin
      SLOW_OSC_RUN <= osc_lock || !halt_req_q; // R5
      // Low-power gating only while unlocked
      WDT_TICK <= tick_rise && (osc_lock || !halt_req_q)
                  && !(!osc_lock && (halt_q || stop_q)); // R6
      TIMER_TICK <= tick_rise && (osc_lock || !halt_req_q); // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe
  logic rd_opt_q, rd_misc_q;
  logic [7:0] misc_q;

  assign st_ridx = 3'(REG_ADDR - REG_WDT_OSC);

  always_ff @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_opt_q <= 1'b0;
      rd_misc_q <= 1'b0;
      misc_q <= 8'h00;
    end else begin
      rd_opt_q <= REG_RD && REG_ADDR >= REG_WDT_OSC
                  && REG_ADDR <= REG_DEBUG;
      rd_misc_q <= REG_RD;
      unique case (REG_ADDR)
        REG_OSC_CTRL: misc_q <= {7'h00, halt_req_q};
        REG_STATUS: misc_q <= {5'h00, swap_used_q, SLOW_OSC_RUN, done};
        default: misc_q <= 8'h00;
      endcase
    end
  end
  assign REG_RDATA = rd_opt_q ? st_rdata : (rd_misc_q ? misc_q : 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_window_decode: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    done |=> WDT_WINDOW == $past(opt_wdt_q[6:5])) // R1
    else $error("window mismatch");
  chk_autostart_run: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    done |=> WDT_RUN == ILLEGAL_ACCESS_EN) // R2
    else $error("autostart split");
  chk_period_value: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    done |=> WDT_OVERFLOW_CYCLES == (WDT_BASE_CYCLES << $past(period_code))) // R3
    else $error("period wrong");
  chk_osc_locked: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    osc_lock |=> SLOW_OSC_RUN) // R5
    else $error("locked osc stopped");
  chk_wdt_gated: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    (!osc_lock && (halt_q || stop_q)) |=> !WDT_TICK) // R6
    else $error("wdt clock in low power");
  chk_timer_tick: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    (tick_rise && osc_lock) |=> TIMER_TICK) // R7
    else $error("timer tick lost");
  chk_cpu_hold: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    CPU_START |-> state_q == ST_DONE) // R19
    else $error("cpu started early");
  chk_alt_fetch: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    FLASH_RD |-> FLASH_ADDR[12] == swap_used_q) // R18
    else $error("wrong option set");
  chk_poc_default: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    (st_wr && idx_q == IDX_POC && !(prog_q && erased_q))
    |=> !opt_poc_q[0]) // R11
    else $error("mode set without programmer");
  chk_settings_hold: assert property (@(posedge CLOCK) disable iff (!rst_n_i)
    CPU_START && $past(CPU_START) |-> $stable(DEBUG_EN)) // R20
    else $error("settings changed");
endmodule : option_byte_config_decoder
`default_nettype wire

/* File: dv/flash_model.sv */
/*
 Behavioural flash array holding primary and alternate option byte sets.
 Assumes the bench fills mem before reset; answers a read two clocks on.
*/
`default_nettype none
module flash_model (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic rd,
  input wire logic [12:0] addr,
  output logic [7:0] data,
  // Mode byte copy port
  input wire logic copy_wr,
  input wire logic [7:0] copy_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Slots 0..4 primary set, 5..9 alternate set
  logic [7:0] mem [0:9];
  logic [1:0] hold_q;
  logic [3:0] slot;
  assign slot = {1'b0, addr[2:0]} + (addr[12] ? 4'h5 : 4'h0);
  initial begin
    data = 8'ha5;
    hold_q = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Data holds only its two valid clocks, then inverts so a late sample
  // never sees a stale but plausible byte
  always @(posedge clk) begin
    if (rd) begin
      data <= mem[slot];
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
      if (hold_q == 2'h1) begin
        data <= ~data;
      end
    end
    if (copy_wr) begin
      mem[1] <= copy_data;
    end
  end
endmodule : flash_model
`default_nettype wire

/* File: dv/tb_top.sv */
/*
 Self-checking bench for the option byte loader: option set loads,
 boot swap, decoded settings, register port and slow clock gating.
 Assumes the flash model answers reads and the clock runs at 25 MHz.
*/
`default_nettype none
module tb_top;
  import optcfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0, RST_N = 1'b0, BOOT_SWAP = 1'b0;
  logic EXT_PROGRAMMER = 1'b0, CHIP_ERASED = 1'b0;
  logic HALT_MODE = 1'b0, STOP_MODE = 1'b0, SLOW_OSC_TICK = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  logic REG_WR = 1'b0, REG_RD = 1'b0;
  logic FLASH_RD, POC_COPY_WR, CPU_START, WDT_RUN, ILLEGAL_ACCESS_EN;
  logic SLOW_OSC_RUN, WDT_TICK, TIMER_TICK, POC_DUAL, DEBUG_EN;
  logic DEBUG_ERASE_ON_FAIL;
  logic [12:0] FLASH_ADDR;
  logic [7:0] FLASH_DATA, POC_COPY_DATA, REG_RDATA, rd_q;
  logic [1:0] WDT_WINDOW;
  logic [17:0] WDT_OVERFLOW_CYCLES;
  int error_cnt = 0, n_checks = 0, rd_cnt = 0, wdt_n = 0, tmr_n = 0;
  // Option sets; debug code 01 is loaded on purpose to test its decode
  logic [7:0] cw [4] = '{8'h30, 8'h5f, 8'h0a, 8'h26};
  logic [7:0] cp [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
  logic [7:0] cd [4] = '{8'h02, 8'h03, 8'h01, 8'h00};
  logic cs [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic ce [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic cx [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  always #20 CLOCK = ~CLOCK;

  option_byte_config_decoder option_byte_config_decoder_i (.CLOCK(CLOCK),
    .RST_N(RST_N), .FLASH_RD(FLASH_RD), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_DATA(FLASH_DATA), .POC_COPY_WR(POC_COPY_WR),
    .POC_COPY_DATA(POC_COPY_DATA), .BOOT_SWAP(BOOT_SWAP),
    .EXT_PROGRAMMER(EXT_PROGRAMMER), .CHIP_ERASED(CHIP_ERASED),
    .HALT_MODE(HALT_MODE), .STOP_MODE(STOP_MODE),
    .SLOW_OSC_TICK(SLOW_OSC_TICK), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CPU_START(CPU_START), .WDT_WINDOW(WDT_WINDOW),
    .WDT_RUN(WDT_RUN), .ILLEGAL_ACCESS_EN(ILLEGAL_ACCESS_EN),
    .WDT_OVERFLOW_CYCLES(WDT_OVERFLOW_CYCLES), .SLOW_OSC_RUN(SLOW_OSC_RUN),
    .WDT_TICK(WDT_TICK), .TIMER_TICK(TIMER_TICK), .POC_DUAL(POC_DUAL),
    .DEBUG_EN(DEBUG_EN), .DEBUG_ERASE_ON_FAIL(DEBUG_ERASE_ON_FAIL));

  flash_model flash_model_i (.clk(CLOCK), .rd(FLASH_RD), .addr(FLASH_ADDR),
    .data(FLASH_DATA), .copy_wr(POC_COPY_WR), .copy_data(POC_COPY_DATA));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [17:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    @(negedge CLOCK);
    rd_q = REG_RDATA;
  endtask : reg_rd

  //////////////////////////////////////////////////////////////////////////
  // Every fetch must walk the chosen address set in order
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      rd_cnt <= 0;
    end else if (FLASH_RD) begin
      check("flash_addr", {4'h0, FLASH_ADDR}, {4'h0, (BOOT_SWAP ?
        OPT_BASE_ALTERNATE : OPT_BASE_PRIMARY) + 13'(rd_cnt)});
      rd_cnt <= rd_cnt + 1;
    end
    if (WDT_TICK) wdt_n++;
    if (TIMER_TICK) tmr_n++;
  end

  // Loads one option set into the selected flash set, a decoy into the other
  task automatic load_cfg(input int i);
    int n;
    for (int k = 0; k < 5; k++) begin
      flash_model_i.mem[k] = 8'h00;
      flash_model_i.mem[k + 5] = 8'h00;
    end
    n = cs[i] ? 5 : 0;
    flash_model_i.mem[n] = cw[i];
    flash_model_i.mem[n + 1] = cp[i];
    flash_model_i.mem[n + 4] = cd[i];
    n = cs[i] ? 0 : 5;
    flash_model_i.mem[n] = cw[i] ^ 8'h40;
    flash_model_i.mem[n + 1] = cp[i] ^ 8'h01;
    flash_model_i.mem[n + 4] = (cd[i] == 8'h03) ? 8'h02 : 8'h03;
    @(posedge CLOCK);
    RST_N <= 1'b0;
    BOOT_SWAP <= cs[i];
    EXT_PROGRAMMER <= ce[i];
    CHIP_ERASED <= cx[i];
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    n = 0;
    while (CPU_START !== 1'b1 && n < 200) begin
      @(posedge CLOCK);
      n++;
    end
    @(negedge CLOCK);
    check("cpu_start", 17'(CPU_START), 17'h1);
    check("fetch_count", 17'(rd_cnt), 17'd5);
    check("window", 17'(WDT_WINDOW), 17'(cw[i][6:5]));
    check("wdt_run", 17'(WDT_RUN), 17'(cw[i][4]));
    check("illegal_en", 17'(ILLEGAL_ACCESS_EN), 17'(cw[i][4]));
    check("overflow", WDT_OVERFLOW_CYCLES, 18'h00400 << cw[i][3:1]);
    check("poc_dual", 17'(POC_DUAL), 17'(cp[i][0] & ce[i] & cx[i]));
    check("debug_en", 17'(DEBUG_EN), 17'(cd[i][1]));
    check("debug_erase", 17'(DEBUG_ERASE_ON_FAIL), 17'(cd[i] == 8'h03));
    if (cs[i]) begin
      check("poc_copy", 17'(flash_model_i.mem[1]), 17'(cp[i]));
    end
    flash_model_i.mem[0] = 8'h00;
    flash_model_i.mem[5] = 8'h00;
    reg_wr(REG_WDT_OSC, 8'hff);
    reg_rd(REG_WDT_OSC);
    check("reg_wdt_osc", 17'(rd_q), 17'(cw[i]));
    reg_rd(REG_DEBUG);
    check("reg_debug", 17'(rd_q), 17'(cd[i]));
    reg_rd(REG_RSVD0);
    check("reg_rsvd", 17'(rd_q), 17'h0);
    reg_rd(8'h95);
    check("reg_unmapped", 17'(rd_q), 17'h0);
    reg_rd(REG_STATUS);
    check("status", 17'(rd_q[2:0]), {14'h0, cs[i], 2'b11});
    check("window_held", 17'(WDT_WINDOW), 17'(cw[i][6:5]));
    $display("option set %0d done", i);
  endtask : load_cfg

  task automatic ticks(input int n, ew, et);
    @(posedge CLOCK);
    wdt_n = 0;
    tmr_n = 0;
    repeat (n) begin
      SLOW_OSC_TICK <= 1'b1;
      repeat (4) @(posedge CLOCK);
      SLOW_OSC_TICK <= 1'b0;
      repeat (4) @(posedge CLOCK);
    end
    repeat (10) @(posedge CLOCK);
    check("wdt_ticks", 17'(wdt_n), 17'(ew));
    check("timer_ticks", 17'(tmr_n), 17'(et));
  endtask : ticks

  // Slow oscillator gating with the lock bit clear or set
  task automatic osc_test(input logic lock);
    @(posedge CLOCK);
    ticks(3, 3, 3);
    if (!lock) begin
      HALT_MODE <= 1'b1;
      ticks(3, 0, 3);
      HALT_MODE <= 1'b0;
      STOP_MODE <= 1'b1;
      ticks(3, 0, 3);
      STOP_MODE <= 1'b0;
    end
    reg_wr(REG_OSC_CTRL, 8'h01);
    reg_rd(REG_OSC_CTRL);
    check("halt_req", 17'(rd_q), 17'h1);
    check("osc_run", 17'(SLOW_OSC_RUN), 17'(lock));
    reg_rd(REG_STATUS);
    check("status_run", 17'(rd_q[1]), 17'(lock));
    ticks(3, lock ? 3 : 0, lock ? 3 : 0);
    reg_wr(REG_OSC_CTRL, 8'h00);
    @(posedge CLOCK);
    @(negedge CLOCK);
    check("osc_rerun", 17'(SLOW_OSC_RUN), 17'h1);
    $display("oscillator test lock %0d done", lock);
  endtask : osc_test

  initial begin
    for (int i = 0; i < 4; i++) begin
      load_cfg(i);
      if (i < 2) osc_test(cw[i][0]);
    end
    wrap_up();
  end

  initial begin
    #(40 * 20000);
    error_cnt++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
